// ===== src/smsr_avalon_slave.v
// smsr_avalon_slave.v: Avalon-MM slave front end with one wait state per access
// assumes a master that holds its request until waitrequest is seen low
`default_nettype none
`timescale 1ns/1ps

module smsr_avalon_slave (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // avalon side
  input  wire        avs_read,
  input  wire        avs_write,
  output wire        avs_waitrequest,
  // register side
  output wire        rd_strobe,
  output wire        wr_strobe
);

  reg ack;

  // ack rises one cycle after a request and drops after completion
  always @(posedge core_clk) begin
    if (rst) begin
      ack <= 1'b0;
    end else if ((avs_read | avs_write) & ~ack) begin
      ack <= 1'b1;
    end else begin
      ack <= 1'b0;
    end
  end

  // waitrequest held high until ack
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  // read data is loaded in the wait cycle so it stands at the completing edge
  assign rd_strobe       = avs_read & ~ack;
  assign wr_strobe       = avs_write & ack;

endmodule // smsr_avalon_slave

`default_nettype wire

// ===== src/smsr_defines.vh
// smsr_defines.vh: offsets, field positions and reset values of the switch status bank
// assumes it is included by its bare name from the design files
`ifndef SMSR_DEFINES_VH
`define SMSR_DEFINES_VH

// register byte addresses
`define SMSR_EXC_OFFSET        32'h000021b0
`define SMSR_POS_OFFSET        32'h000021b4
`define SMSR_NEG_OFFSET        32'h000021b8

// reset values
`define SMSR_EXC_RESET         32'h00000000
`define SMSR_POS_RESET         32'h00000000
`define SMSR_NEG_RESET         32'h00000000

// excitation-output fields
`define SMSR_EXC_CAL_BIT       0
`define SMSR_EXC_SW_LSB        1
`define SMSR_EXC_SW_MSB        6
`define SMSR_EXC_WIDTH         7

// positive-input fields
`define SMSR_POS_CAL_BIT       0
`define SMSR_POS_SW_LSB        1
`define SMSR_POS_SW_MSB        8
`define SMSR_POS_SW11_BIT      10
`define SMSR_POS_SW13_BIT      12
`define SMSR_POS_LOAD_BIT      13
`define SMSR_POS_LOAD2_BIT     14
`define SMSR_POS_WIDTH         15

// negative-input fields
`define SMSR_NEG_SW_LSB        0
`define SMSR_NEG_SW_MSB        6
`define SMSR_NEG_SW9_BIT       8
`define SMSR_NEG_CAL_BIT       9
`define SMSR_NEG_LOAD_BIT      10
`define SMSR_NEG_LOAD2_BIT     11
`define SMSR_NEG_WIDTH         12

// bus answer for an unmapped read
`define SMSR_UNMAPPED_DATA     32'h00000000

`endif

// ===== src/smsr_switch_status.v
// smsr_switch_status.v: read-only status bank for the analog switch matrix
// assumes switch states arrive as asynchronous levels from the switch control logic
`include "smsr_defines.vh"
`default_nettype none
`timescale 1ns/1ps

// Notes on behaviour
// - excitation status register at 0x21b0, read-only, resets to zero
// - excitation bit 6 is switch 7; bits 31..7 read zero
// - excitation bits 5..1 are switches 6..2; bit 0 calibration switch
// - positive-input status register at 0x21b4, read-only, resets to zero
// - positive bits 14,13,12,10 load2, load, sw13, sw11; others above 8 zero
// - positive bits 8..1 are switches 9..2; bit 0 calibration switch
// - negative-input status register at 0x21b8, read-only, resets to zero
// - negative bits 11,10,9,8 load2, load, cal, sw9; bit 7 and 31..12 zero
// - negative bits 6..0 are switches 7..1
module smsr_switch_status (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // avalon-mm register bus
  input  wire [31:0] avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // excitation-output switch states, 1 = closed
  input  wire        exc_out_cal_sw_closed,
  input  wire [5:0]  exc_out_sw_closed,      // index 0 is switch 2, index 5 is switch 7
  // positive-input switch states
  input  wire        pos_cal_sw_closed,
  input  wire [7:0]  pos_sw_closed,          // index 0 is switch 2, index 7 is switch 9
  input  wire        pos_sw11_closed,
  input  wire        pos_sw13_closed,
  input  wire        pos_load_sw_closed,
  input  wire        pos_load_sw2_closed,
  // negative-input switch states
  input  wire [6:0]  neg_sw_closed,          // index 0 is switch 1, index 6 is switch 7
  input  wire        neg_sw9_closed,
  input  wire        neg_cal_sw_closed,
  input  wire        neg_load_sw_closed,
  input  wire        neg_load_sw2_closed
);

  wire [`SMSR_EXC_WIDTH-1:0] exc_raw;
  wire [`SMSR_POS_WIDTH-1:0] pos_raw;
  wire [`SMSR_NEG_WIDTH-1:0] neg_raw;
  wire [`SMSR_EXC_WIDTH-1:0] exc_sync;
  wire [`SMSR_POS_WIDTH-1:0] pos_sync;
  wire [`SMSR_NEG_WIDTH-1:0] neg_sync;
  wire                       rd_strobe;
  wire                       wr_strobe;
  reg  [31:0]                excitation_switch_status;
  reg  [31:0]                positive_input_switch_status;
  reg  [31:0]                negative_input_switch_status;
  reg  [31:0]                next_readdata;

  // excitation field packing
  assign exc_raw[`SMSR_EXC_CAL_BIT]                      = exc_out_cal_sw_closed;
  assign exc_raw[`SMSR_EXC_SW_MSB:`SMSR_EXC_SW_LSB]      = exc_out_sw_closed;

  // positive field packing, reserved bits tied low
  assign pos_raw[`SMSR_POS_CAL_BIT]                      = pos_cal_sw_closed;
  assign pos_raw[`SMSR_POS_SW_MSB:`SMSR_POS_SW_LSB]      = pos_sw_closed;
  assign pos_raw[`SMSR_POS_SW_MSB+1]                     = 1'b0;
  assign pos_raw[`SMSR_POS_SW11_BIT]                     = pos_sw11_closed;
  assign pos_raw[`SMSR_POS_SW11_BIT+1]                   = 1'b0;
  assign pos_raw[`SMSR_POS_SW13_BIT]                     = pos_sw13_closed;
  assign pos_raw[`SMSR_POS_LOAD_BIT]                     = pos_load_sw_closed;
  assign pos_raw[`SMSR_POS_LOAD2_BIT]                    = pos_load_sw2_closed;

  // negative field packing, bit 7 reserved
  assign neg_raw[`SMSR_NEG_SW_MSB:`SMSR_NEG_SW_LSB]      = neg_sw_closed;
  assign neg_raw[`SMSR_NEG_SW_MSB+1]                     = 1'b0;
  assign neg_raw[`SMSR_NEG_SW9_BIT]                      = neg_sw9_closed;
  assign neg_raw[`SMSR_NEG_CAL_BIT]                      = neg_cal_sw_closed;
  assign neg_raw[`SMSR_NEG_LOAD_BIT]                     = neg_load_sw_closed;
  assign neg_raw[`SMSR_NEG_LOAD2_BIT]                    = neg_load_sw2_closed;

  // bring switch levels into core_clk
  smsr_sync #(.WIDTH(`SMSR_EXC_WIDTH)) u_sync_exc (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (exc_raw),
    .sync_out (exc_sync)
  );

  smsr_sync #(.WIDTH(`SMSR_POS_WIDTH)) u_sync_pos (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (pos_raw),
    .sync_out (pos_sync)
  );

  smsr_sync #(.WIDTH(`SMSR_NEG_WIDTH)) u_sync_neg (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (neg_raw),
    .sync_out (neg_sync)
  );

  // bus handshake
  smsr_avalon_slave u_slave (
    .core_clk        (core_clk),
    .rst             (rst),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_waitrequest (avs_waitrequest),
    .rd_strobe       (rd_strobe),
    .wr_strobe       ()
  );

  // status registers track synchronised switch states every cycle
  always @(posedge core_clk) begin
    if (rst) begin
      excitation_switch_status     <= `SMSR_EXC_RESET;
      positive_input_switch_status <= `SMSR_POS_RESET;
      negative_input_switch_status <= `SMSR_NEG_RESET;
    end else begin
      excitation_switch_status     <= {{(32-`SMSR_EXC_WIDTH){1'b0}}, exc_sync};
      positive_input_switch_status <= {{(32-`SMSR_POS_WIDTH){1'b0}}, pos_sync};
      negative_input_switch_status <= {{(32-`SMSR_NEG_WIDTH){1'b0}}, neg_sync};
    end
  end

  // read decode; writes have no path into the registers
  always @* begin
    next_readdata = avs_readdata;
    if (rd_strobe) begin
      case (avs_address)
        `SMSR_EXC_OFFSET: next_readdata = excitation_switch_status;
        `SMSR_POS_OFFSET: next_readdata = positive_input_switch_status;
        `SMSR_NEG_OFFSET: next_readdata = negative_input_switch_status;
        default:          next_readdata = `SMSR_UNMAPPED_DATA;
      endcase
    end
  end

  // read data register, loaded at the request edge so it stands at the completing edge
  always @(posedge core_clk) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else begin
      avs_readdata <= next_readdata;
    end
  end

endmodule // smsr_switch_status

`default_nettype wire

// ===== src/smsr_sync.v
// smsr_sync.v: two flip-flop synchroniser, one per bit, for switch state levels
// assumes the inputs are levels from outside the core_clk domain
`default_nettype none
`timescale 1ns/1ps

module smsr_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             rst,
  // levels
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;

  // per bit: first stage feeds only the second
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg stage1;
      reg stage2;
      always @(posedge core_clk) begin
        if (rst) begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
        end else begin
          stage1 <= async_in[i];
          stage2 <= stage1;
        end
      end
      assign sync_out[i] = stage2;
    end
  endgenerate

endmodule // smsr_sync

`default_nettype wire

// ===== tb/smsr_props.sv
// smsr_props.sv: assertions on the bus ports of the switch status bank
// assumes requests are held until waitrequest is low
`timescale 1ns/1ps
`default_nettype none
`include "smsr_defines.vh"
module smsr_props (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // bus
  input wire logic [31:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest
);
  // completed accesses
  wire logic        rd = avs_read & ~avs_waitrequest;
  wire logic        wr = avs_write & ~avs_waitrequest;
  wire logic [31:0] ad = avs_address;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // bus timing and reset
  property p_first; $rose(avs_read | avs_write) |-> avs_waitrequest; endproperty
  a_first: assert property (p_first) else $error("no wait state");
  property p_one; (avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("answer late");
  property p_rst; disable iff (1'b0) rst |=> avs_readdata == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset data not zero");
  // reserved bits and unmapped places
  property p_exc; rd && ad == `SMSR_EXC_OFFSET |=> avs_readdata[31:7] == 25'h0; endproperty
  a_exc: assert property (p_exc) else $error("excitation reserved bits set");
  property p_pos;
    rd && ad == `SMSR_POS_OFFSET |=> avs_readdata[31:15] == 17'h0 && !avs_readdata[11] && !avs_readdata[9];
  endproperty
  a_pos: assert property (p_pos) else $error("positive reserved bits set");
  property p_neg; rd && ad == `SMSR_NEG_OFFSET |=> avs_readdata[31:12] == 20'h0 && !avs_readdata[7]; endproperty
  a_neg: assert property (p_neg) else $error("negative reserved bits set");
  property p_unm;
    rd && ad != `SMSR_EXC_OFFSET && ad != `SMSR_POS_OFFSET && ad != `SMSR_NEG_OFFSET |=> avs_readdata == 32'h0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  // a write leaves the read data alone
  property p_wr; wr |=> $stable(avs_readdata); endproperty
  a_wr: assert property (p_wr) else $error("write changed read data");
  c_exc: cover property (rd && ad == `SMSR_EXC_OFFSET);
  c_wr: cover property (wr);
  c_unm: cover property (rd && ad == 32'h000021bc);
endmodule // smsr_props
bind smsr_switch_status smsr_props u_props (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
`default_nettype wire

// ===== tb/test_switch_matrix_status_regs.sv
// test_switch_matrix_status_regs.sv: self-checking bench for the switch status bank
// assumes one wait state per access and read data loaded at the request edge, so it stands at the completing edge
`timescale 1ns/1ps
`default_nettype none
`include "smsr_defines.vh"
module test_switch_matrix_status_regs;
  logic        core_clk, rst, avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_address, avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic [30:0] sw;
  logic [15:0] lfsr_state;
  logic [31:0] exp_q[$], addr_q[$];
  int          failures, comparisons, cycles;
  // device under test
  smsr_switch_status DUT (.core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .exc_out_cal_sw_closed(sw[0]),
    .exc_out_sw_closed(sw[6:1]), .pos_cal_sw_closed(sw[7]), .pos_sw_closed(sw[15:8]), .pos_sw11_closed(sw[16]),
    .pos_sw13_closed(sw[17]), .pos_load_sw_closed(sw[18]), .pos_load_sw2_closed(sw[19]),
    .neg_sw_closed(sw[26:20]), .neg_sw9_closed(sw[27]), .neg_cal_sw_closed(sw[28]),
    .neg_load_sw_closed(sw[29]), .neg_load_sw2_closed(sw[30]));
  // lfsr step
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // compare one value
  task automatic check(input logic [31:0] addr, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch readdata at %h expected %h seen %h", addr, exp, seen);
    end
  endtask
  // counts, verdict and end of run
  task automatic finish_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one bus access held until waitrequest is seen low; a read notes its expected data
  task automatic access(input logic wr, input logic [31:0] addr, input logic [31:0] exp);
    if (!wr) begin
      exp_q.push_back(exp);
      addr_q.push_back(addr);
    end
    @(posedge core_clk);
    lfsr_state = lfsr(lfsr_state);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= addr;
    avs_writedata <= {lfsr_state, ~lfsr_state};
    avs_byteenable <= lfsr_state[3:0];
    do
      @(posedge core_clk);
    while (avs_waitrequest);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // watcher: read data taken at the edge where a read completes; hang limit
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 20000) begin
      failures++;
      finish_test();
    end
    if (!rst && avs_read === 1'b1 && avs_waitrequest === 1'b0)
      check(addr_q.pop_front(), avs_readdata, exp_q.pop_front());
  end
  // main sequence
  initial begin
    rst = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable, sw} = '0;
    {failures, comparisons, cycles} = '0;
    lfsr_state = 16'h47bd;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    // reset values and one unmapped place
    for (int a = 0; a < 4; a++)
      access(1'b0, 32'h000021b0 + 32'(4 * a), 32'h0);
    $display("test reset values done");
    // all-ones then random switch states, an ignored write six cycles later, then three reads, each one idle cycle after the last access
    for (int i = 0; i < 24; i++) begin
      @(posedge core_clk);
      sw <= (i == 0) ? '1 : {lfsr_state[14:0], lfsr(lfsr_state)};
      repeat (5) @(posedge core_clk);
      access(1'b1, 32'h000021b0 + 32'(4 * (i % 3)), 32'h0);
      access(1'b0, `SMSR_EXC_OFFSET, {25'h0, sw[6:0]});
      access(1'b0, `SMSR_POS_OFFSET, {17'h0, sw[19:17], 1'b0, sw[16], 1'b0, sw[15:7]});
      access(1'b0, `SMSR_NEG_OFFSET, {20'h0, sw[30:27], 1'b0, sw[26:20]});
    end
    $display("test switch mapping done");
    repeat (3) @(posedge core_clk);
    finish_test();
  end
endmodule // test_switch_matrix_status_regs
`default_nettype wire
